// ### pfs_analog_model.sv
// Analog side model: output voltage level to comparator results.
`timescale 1ns/1ps
module pfs_analog_model #(
  parameter int VIN_MV = 3600 // Supply level in mV, plain default.
) (
  input wire logic [15:0] vout_mv_i, // Modelled output voltage in mV.
  output logic short_cmp_o, // Output below 55 pct of supply.
  output logic ovp_high_cmp_o, // Output above over-voltage threshold.
  output logic ovp_low_cmp_o, // Output below hysteresis release level.
  output logic clamp_cmp_o // Output at the clamp level.
);
  // Levels are static, so the model never glitches between test steps.
  assign short_cmp_o = (32'(vout_mv_i) * 100) < (VIN_MV * 55);
  assign ovp_high_cmp_o = vout_mv_i > 16'h16A8;
  assign ovp_low_cmp_o = vout_mv_i < 16'h14B4;
  assign clamp_cmp_o = vout_mv_i >= 16'h1324;
endmodule : pfs_analog_model

// ### pfs_params.svh
// Constants, flag indices and gain codes for the pump fault supervisor.
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH
`define PFS_CLK_MHZ 20
`define PFS_BLANK_US 4000
`define PFS_BLANK_CYC (`PFS_BLANK_US * `PFS_CLK_MHZ)
`define PFS_CNT_W 17
`define PFS_CHANNELS 7
`define PFS_SOFT_US 1
`define PFS_SOFT_CYC (`PFS_SOFT_US * `PFS_CLK_MHZ)
`define PFS_FLAG_OV 0
`define PFS_FLAG_SC 1
`define PFS_FLAG_W 2
`define PFS_GAIN_1X 2'h0
`define PFS_GAIN_1P5X 2'h1
`define PFS_GAIN_2X 2'h2
`endif

// ### pfs_pkg.sv
// Types for the pump fault supervisor.
package pfs_pkg;
  typedef enum logic [2:0] {
    PFS_IDLE = 3'b000,
    PFS_SOFT = 3'b001,
    PFS_RUN = 3'b011,
    PFS_OVP = 3'b010,
    PFS_SHORT = 3'b110
  } pfs_state_type;
endpackage : pfs_pkg

// ### pfs_supervisor.sv
// Charge pump fault supervisor: short, over-voltage, gain and flags.
`timescale 1ns/1ps
`include "pfs_params.svh"
module pfs_supervisor
  import pfs_pkg::*;
(
  input wire logic clk_i, // 20 MHz clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic active_request_i, // Active request bit level.
  input wire logic active_request_wr_i, // Pulse: active request written.
  input wire logic gain_step_down_inhibit_i, // Forbid gain step-down.
  input wire logic short_cmp_i, // Async: output below 55 pct of input.
  input wire logic ovp_high_cmp_i, // Async: output above 5.8 V.
  input wire logic ovp_low_cmp_i, // Async: output below 5.3 V.
  input wire logic clamp_cmp_i, // Async: output at clamp level.
  input wire logic [6:0] headroom_low_i, // Per sink: headroom too low.
  input wire logic [6:0] headroom_high_i, // Per sink: headroom ample.
  input wire logic [1:0] flag_clear_i, // Pulse: write one to clear.
  input wire logic [1:0] irq_enable_mask_i, // Interrupt enables.
  output logic pump_en_o, // Charge pump running.
  output logic [1:0] gain_o, // Selected pump gain.
  output logic rout_boost_o, // Raise effective output resistance.
  output logic sinks_en_o, // Current sinks enabled.
  output logic low_power_o, // Low current consumption state.
  output logic [1:0] flag_register_o, // Over-voltage and short flags.
  output logic irq_out_n_o // Interrupt, active low.
);
  // ****************************************************************
  // Synchronisation
  // ****************************************************************
  logic [3:0] cmp_s;
  logic short_s, ovh_s, ovl_s, clamp_s;
  pfs_sync #(.WIDTH(4)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i({clamp_cmp_i, ovp_low_cmp_i, ovp_high_cmp_i, short_cmp_i}),
    .sync_o(cmp_s)
  );
  assign short_s = cmp_s[0];
  assign ovh_s = cmp_s[1];
  assign ovl_s = cmp_s[2];
  assign clamp_s = cmp_s[3];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  pfs_state_type state, next_state;
  logic [`PFS_CNT_W-1:0] blank_cnt;
  logic sense_en;
  logic short_hit, ov_entry;

  // Blanking runs from every entry into soft start, so a restart is also masked.
  assign sense_en = (blank_cnt == `PFS_CNT_W'(`PFS_BLANK_CYC));
  assign short_hit = sense_en && short_s &&
                     (state == PFS_RUN || state == PFS_SOFT);
  // Entry is taken from the chosen next state, so a dropped request
  // that wins over the threshold leaves no stray flag behind.
  assign ov_entry = (state == PFS_RUN) &&
                    (next_state == PFS_OVP);

  always_comb begin
    next_state = state;
    case (state)
      PFS_IDLE: begin
        if (active_request_i) begin
          next_state = PFS_SOFT;
        end
      end
      PFS_SOFT: begin
        if (short_hit) begin
          next_state = PFS_SHORT;
        end else if (blank_cnt >= `PFS_CNT_W'(`PFS_SOFT_CYC)) begin
          next_state = PFS_RUN;
        end
      end
      PFS_RUN: begin
        if (short_hit) begin
          next_state = PFS_SHORT;
        end else if (ovh_s) begin
          next_state = PFS_OVP;
        end
      end
      PFS_OVP: begin
        if (ovl_s && !ovh_s) begin
          next_state = PFS_RUN;
        end
      end
      PFS_SHORT: begin
        if (active_request_wr_i && active_request_i) begin
          next_state = PFS_SOFT;
        end
      end
      default: begin
        next_state = PFS_IDLE;
      end
    endcase
    if (!active_request_i) begin
      next_state = PFS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= PFS_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Counter restarts on each entry into soft start and saturates.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blank_cnt <= '0;
    end else if (ce_i) begin
      if (next_state == PFS_SOFT && state != PFS_SOFT) begin
        blank_cnt <= '0;
      end else if (state == PFS_IDLE || state == PFS_SHORT) begin
        blank_cnt <= '0;
      end else if (!sense_en) begin
        blank_cnt <= blank_cnt + `PFS_CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pump_en_o <= 1'b0;
      sinks_en_o <= 1'b0;
      low_power_o <= 1'b1;
      rout_boost_o <= 1'b0;
    end else if (ce_i) begin
      pump_en_o <= (next_state == PFS_SOFT) || (next_state == PFS_RUN);
      // Sinks keep running through over-voltage protection.
      sinks_en_o <= (next_state == PFS_RUN) ||
                    (next_state == PFS_OVP);
      low_power_o <= (next_state == PFS_SHORT) ||
                     (next_state == PFS_IDLE);
      rout_boost_o <= clamp_s && (next_state == PFS_RUN);
    end
  end

  // ****************************************************************
  // Gain selection
  // ****************************************************************
  logic any_low, all_high;
  // Any one starved sink holds the gain up, even if fed elsewhere.
  assign any_low = |headroom_low_i;
  assign all_high = &headroom_high_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gain_o <= `PFS_GAIN_1X;
    end else if (ce_i) begin
      if (state == PFS_IDLE || state == PFS_SHORT) begin
        gain_o <= `PFS_GAIN_1X;
      end else if (state == PFS_RUN) begin
        if (any_low && gain_o != `PFS_GAIN_2X) begin
          gain_o <= gain_o + 2'h1;
        end else if (all_high && !gain_step_down_inhibit_i &&
                     gain_o != `PFS_GAIN_1X) begin
          gain_o <= gain_o - 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Flags and interrupt
  // ****************************************************************
  logic [1:0] set_ev;
  assign set_ev[`PFS_FLAG_OV] = ov_entry;
  assign set_ev[`PFS_FLAG_SC] = (state != PFS_SHORT) &&
                                (next_state == PFS_SHORT);

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_register_o <= '0;
    end else if (ce_i) begin
      flag_register_o <= set_ev |
                         (flag_register_o & ~flag_clear_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_out_n_o <= 1'b1;
    end else if (ce_i) begin
      irq_out_n_o <= ~|((set_ev | (flag_register_o & ~flag_clear_i)) &
                        irq_enable_mask_i);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_short_needs_blank: assert property (
    (state == PFS_SOFT && blank_cnt == '0) |-> !short_hit
  ) else $error("Short sensed during blanking.");

  a_short_stops_pump: assert property (
    (ce_i && short_hit && active_request_i) |=>
      (!pump_en_o && low_power_o && flag_register_o[`PFS_FLAG_SC])
  ) else $error("Short fault did not stop pump.");

  sequence s_short_then_rewrite;
    state == PFS_SHORT ##0 ce_i && active_request_wr_i && active_request_i;
  endsequence
  a_restart_soft: assert property (
    s_short_then_rewrite |=> (state == PFS_SOFT && pump_en_o)
  ) else $error("Restart did not start soft start.");

  a_ov_sinks_on: assert property (
    (ce_i && state == PFS_OVP && next_state == PFS_OVP) |=>
      (!pump_en_o && sinks_en_o)
  ) else $error("Over-voltage did not stop only the pump.");

  a_ov_flag_set: assert property (
    (ce_i && ov_entry) |=> flag_register_o[`PFS_FLAG_OV]
  ) else $error("Over-voltage flag not set.");

  a_gain_no_down: assert property (
    (ce_i && gain_step_down_inhibit_i && state == PFS_RUN) |=>
      (gain_o >= $past(gain_o))
  ) else $error("Gain stepped down while inhibited.");

  a_flag_sticky: assert property (
    (ce_i && flag_register_o[`PFS_FLAG_SC] && !flag_clear_i[`PFS_FLAG_SC])
      |=> flag_register_o[`PFS_FLAG_SC]
  ) else $error("Short flag cleared without write of one.");

  a_irq_masked: assert property (
    (ce_i && irq_enable_mask_i == 2'h0) |=> irq_out_n_o
  ) else $error("Interrupt asserted while masked.");

  a_clamp_no_flag: assert property (
    (ce_i && clamp_s && !ovh_s && state == PFS_RUN && !short_hit) |=>
      !$rose(flag_register_o[`PFS_FLAG_OV])
  ) else $error("Clamp regulation raised a flag.");
endmodule : pfs_supervisor

// ### pfs_supervisor_test.sv
// Self-checking bench for the pump fault supervisor.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module pfs_supervisor_test;
  import pfs_pkg::*;
  logic clk_i, rst_n_i, req, req_wr, inhibit, ce;
  logic pump, rout, sinks, lowp, irq_n, sc, ovh, ovl, clamp;
  logic [6:0] hr_low, hr_high;
  logic [1:0] clr, mask, gain, flags;
  logic [15:0] vout;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int start = 0;
  pfs_supervisor dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .active_request_i(req), .active_request_wr_i(req_wr),
    .gain_step_down_inhibit_i(inhibit), .short_cmp_i(sc),
    .ovp_high_cmp_i(ovh), .ovp_low_cmp_i(ovl), .clamp_cmp_i(clamp),
    .headroom_low_i(hr_low), .headroom_high_i(hr_high),
    .flag_clear_i(clr), .irq_enable_mask_i(mask), .pump_en_o(pump),
    .gain_o(gain), .rout_boost_o(rout), .sinks_en_o(sinks),
    .low_power_o(lowp), .flag_register_o(flags), .irq_out_n_o(irq_n));
  pfs_analog_model model_u (.vout_mv_i(vout), .short_cmp_o(sc),
    .ovp_high_cmp_o(ovh), .ovp_low_cmp_o(ovl), .clamp_cmp_o(clamp));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc++;
  // ****************
  // Access tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic set_vout(input logic [15:0] mv);
    vout = mv;
    tick(5);
  endtask : set_vout
  task automatic write_req(input logic v);
    req = v;
    req_wr = 1'b1;
    tick(1);
    req_wr = 1'b0;
  endtask : write_req
  task automatic clear_flag(input logic [1:0] m);
    clr = m;
    tick(1);
    clr = 2'h0;
    tick(2);
  endtask : clear_flag
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ****************
  // Tests
  // ****************
  initial begin
    vout = 16'h0E10;
    {req, req_wr, inhibit, hr_low, hr_high, clr} = '0;
    mask = 2'h3;
    ce = 1'b1;
    rst_n_i = 1'b0;
    tick(10);
    rst_n_i = 1'b1;
    `CHK({pump, sinks, lowp, irq_n, rout, gain, flags}, 9'b0_0110_0000)
    $display("test reset done");
    // The pump is started before any headroom load is applied.
    write_req(1'b1);
    start = cyc;
    `CHK({pump, sinks, lowp}, 3'b100)
    tick(21);
    `CHK({pump, sinks, lowp}, 3'b110)
    set_vout(16'h03E8);
    `CHK({pump, flags}, 3'b100)
    set_vout(16'h0E10);
    $display("test blank done");
    set_vout(16'h1388);
    `CHK({rout, flags}, 3'b100)
    set_vout(16'h0E10);
    `CHK(rout, 1'b0)
    $display("test clamp done");
    set_vout(16'h1770);
    `CHK({pump, sinks, flags, irq_n}, 5'b0_1010)
    mask = 2'h2;
    tick(2);
    `CHK(irq_n, 1'b1)
    mask = 2'h3;
    clear_flag(2'h2);
    `CHK(flags, 2'h1)
    set_vout(16'h157C);
    `CHK(pump, 1'b0)
    set_vout(16'h1450);
    `CHK(pump, 1'b1)
    clear_flag(2'h1);
    `CHK({flags, irq_n}, 3'b001)
    set_vout(16'h1770);
    `CHK(flags, 2'h1)
    set_vout(16'h1450);
    clear_flag(2'h1);
    $display("test overvoltage done");
    hr_low = 7'h40;
    tick(1);
    hr_low = 7'h00;
    tick(3);
    `CHK(gain, 2'h1)
    inhibit = 1'b1;
    hr_high = 7'h7F;
    tick(5);
    `CHK(gain, 2'h1)
    inhibit = 1'b0;
    hr_high = 7'h3F;
    tick(5);
    `CHK(gain, 2'h1)
    hr_high = 7'h7F;
    tick(5);
    `CHK(gain, 2'h0)
    hr_high = 7'h00;
    // Three cycles of step-up demand would reach 2x unless frozen.
    ce = 1'b0;
    hr_low = 7'h40;
    tick(3);
    `CHK(gain, 2'h0)
    hr_low = 7'h00;
    ce = 1'b1;
    $display("test gain done");
    // The short is applied just before the blank ends and must wait.
    tick(79980 - (cyc - start));
    set_vout(16'h03E8);
    `CHK({pump, lowp, flags}, 4'b1000)
    tick(30);
    `CHK({pump, lowp, sinks, flags, irq_n}, 6'b01_0100)
    write_req(1'b1);
    `CHK(pump, 1'b1)
    tick(5);
    `CHK({pump, lowp, flags}, 4'b1010)
    write_req(1'b0);
    tick(1);
    `CHK({pump, lowp, flags}, 4'b0110)
    mask = 2'h1;
    tick(2);
    `CHK(irq_n, 1'b1)
    $display("test short done");
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
endmodule : pfs_supervisor_test

// ### pfs_sync.sv
// Two flip-flop synchroniser, one bit per lane.
`timescale 1ns/1ps
module pfs_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic [WIDTH-1:0] async_i, // Asynchronous levels.
  output logic [WIDTH-1:0] sync_o // Synchronised levels.
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic meta;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta <= 1'b0;
          sync_o[g] <= 1'b0;
        end else if (ce_i) begin
          meta <= async_i[g];
          sync_o[g] <= meta;
        end
      end
    end
  endgenerate
endmodule : pfs_sync
